/* File: hps_pkg.sv */
// package of constants, types and register map for the two-slot hot-plug slot logic
// assumes an axi4-lite master on ref_clk and analog sense comparators arriving as async levels
// Operation
// RQ1 - rising edge on main enable toggles slot main rails on or off
// RQ2 - enables ignored for turn-on until standby valid and reset interval elapsed
// RQ3 - main enable low after a fault clears the main rail fault latches
// RQ4 - rising edge on standby enable toggles slot standby output on or off
// RQ5 - standby enable low after a fault clears the standby fault latch
// RQ6 - system holds pin enables low when slots are register controlled
// RQ7 - power good asserts only when commanded on and all three rails delivering
// RQ8 - fault output asserts when breaker trips on overcurrent, undervoltage, overtemperature
// RQ9 - main fault output cause clears when main enable goes low
// RQ10 - standby fault output cause clears when standby enable goes low
// RQ11 - with both faults, both enables must go low to release fault
// RQ12 - forced-on input low turns on all three slot outputs
// RQ13 - forced-on suppresses overcurrent, short, thermal and main undervoltage protections
// RQ14 - forced-on keeps standby undervoltage lockout active
// RQ15 - forced-on releases power good and fault outputs
// RQ16 - status registers report true supply state during forced-on
// RQ17 - control bit 2 blocks the slot forced-on input
// RQ18 - current limit longer than filter delay trips breaker and latches fault
// RQ19 - register logic runs from standby supply, usable in standby
// RQ20 - a main rail fault shuts down both main rails of the slot
// RQ21 - interrupt asserts on any fault unless common mask bit 3 is set
// RQ22 - enables synchronised and edge detected, each transition acts once
// RQ23 - latches cleared and outputs off after power-on reset
package hps_pkg;
   // =========================================================
   // register map
   localparam logic [3:0] CTRL_A_OFF   = 4'h0;
   localparam logic [3:0] CTRL_B_OFF   = 4'h4;
   localparam logic [3:0] STAT_A_OFF   = 4'h8;
   localparam logic [3:0] STAT_B_OFF   = 4'hc;
   localparam logic [3:0] COMMON_OFF   = 4'h0;
   localparam logic [4:0] COMMON_ADDR  = 5'h10;
   localparam int         CTRL_MAIN_ON = 0;
   localparam int         CTRL_AUX_ON  = 1;
   localparam int         CTRL_FORCE_BLOCK = 2;
   localparam int         COMMON_MASK  = 3;
   localparam logic [7:0] CTRL_RESET   = 8'h00;
   localparam logic [1:0] AXI_OKAY     = 2'h0;
   localparam logic [1:0] AXI_SLVERR   = 2'h2;
   // sync reset matches idle pins; forced-on is active low, so it resets high
   localparam logic [20:0] SYNC_RESET  = 21'h00c000;
   // =========================================================
   // timing
   localparam int CLK_MHZ              = 25;
   localparam int POR_INTERVAL_US      = 200;
   localparam int POR_CYCLES           = POR_INTERVAL_US * CLK_MHZ;
   localparam int FILTER_DELAY_US      = 20;
   localparam int FILTER_CYCLES        = FILTER_DELAY_US * CLK_MHZ;
   // =========================================================
   // per-slot analog sense, async levels
   typedef struct packed {
      logic main_ilim;
      logic aux_ilim;
      logic main_uv;
      logic aux_uv;
      logic over_temp;
      logic main_good;
      logic aux_good;
   } hps_sense_type;
   // per-slot rail switch drive
   typedef struct packed {
      logic main_on;
      logic aux_on;
   } hps_rail_type;
endpackage

/* File: hps_slot_logic.sv */
// two-slot enable, fault latch, forced-on and status logic behind an axi4-lite slave
// assumes sense levels and pins are asynchronous; bus is synchronous to ref_clk
`timescale 1ns/1ps
module hps_slot_logic #(
   parameter int POR_CYCLES    = hps_pkg::POR_CYCLES,
   parameter int FILTER_CYCLES = hps_pkg::FILTER_CYCLES
) (
   // clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 rst_b,
   input  wire logic                 clk_en,
   // pins, asynchronous
   input  wire logic                 standby_supply_ok,
   input  wire logic [1:0]           main_enable_in,
   input  wire logic [1:0]           standby_rail_enable_in,
   input  wire logic [1:0]           force_on_n,
   input  wire hps_pkg::hps_sense_type [1:0] sense,
   // rail switches
   output hps_pkg::hps_rail_type [1:0]       rail,
   // open-drain outputs, enable high pulls low
   output logic [1:0]                power_good_n_o,
   output logic [1:0]                power_good_n_oe,
   output logic [1:0]                fault_n_o,
   output logic [1:0]                fault_n_oe,
   output logic                      irq_n_o,
   output logic                      irq_n_oe,
   // axi4-lite slave
   input  wire logic [4:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [4:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready
);
   // =========================================================
   // synchronisers: 2 + 2 + 2 + 14 sense + 1 supply
   localparam int NS = 21;
   logic [NS-1:0] sync1;
   logic [NS-1:0] sync2;
   logic [NS-1:0] raw;
   assign raw = {standby_supply_ok, main_enable_in, standby_rail_enable_in, force_on_n, sense};
   always_ff @(posedge ref_clk or negedge rst_b) begin // [RQ22]
      if (!rst_b) begin
         sync1 <= hps_pkg::SYNC_RESET;
         sync2 <= hps_pkg::SYNC_RESET;
      end else if (clk_en) begin
         sync1 <= raw;
         sync2 <= sync1;
      end
   end
   logic                         sup_ok;
   logic [1:0]                   en_main;
   logic [1:0]                   en_aux;
   logic [1:0]                   frc_n;
   hps_pkg::hps_sense_type [1:0] sn;
   assign {sup_ok, en_main, en_aux, frc_n, sn} = sync2;

   // =========================================================
   // power-on reset interval; registers stay reachable throughout
   logic [$clog2(POR_CYCLES+1)-1:0] por_cnt;
   logic                            por_done;
   always_ff @(posedge ref_clk or negedge rst_b) begin // [RQ2] [RQ19]
      if (!rst_b) begin
         por_cnt  <= '0;
         por_done <= 1'b0;
      end else if (clk_en) begin
         if (!sup_ok) begin
            por_cnt  <= '0;
            por_done <= 1'b0;
         end else if (por_cnt == ($bits(por_cnt))'(POR_CYCLES)) begin
            por_done <= 1'b1;
         end else begin
            por_cnt <= por_cnt + 1'b1;
         end
      end
   end

   // =========================================================
   // registers
   logic [1:0][7:0] slot_control_reg;
   logic            interrupt_mask_bit;
   logic [1:0]      main_on;
   logic [1:0]      aux_on;
   logic [1:0]      main_flt;
   logic [1:0]      aux_flt;
   logic [1:0]      forced;
   logic [1:0]      main_prev;
   logic [1:0]      aux_prev;
   logic            wr_fire;
   logic [4:0]      wr_addr;
   logic [31:0]     wr_data;
   logic [1:0]      reg_main_set;
   logic [1:0]      reg_aux_set;

   genvar s;
   generate
      for (s = 0; s < 2; s++) begin : g_slot
         logic [$clog2(FILTER_CYCLES+1)-1:0] main_tmr;
         logic [$clog2(FILTER_CYCLES+1)-1:0] aux_tmr;
         logic                               main_trip;
         logic                               aux_trip;
         logic                               main_rise;
         logic                               aux_rise;
         assign forced[s] = !frc_n[s] && !slot_control_reg[s][hps_pkg::CTRL_FORCE_BLOCK]; // [RQ17]
         assign main_rise = en_main[s] && !main_prev[s]; // [RQ22]
         assign aux_rise  = en_aux[s] && !aux_prev[s];
         // current-limit timers; a brief spike does not trip
         always_ff @(posedge ref_clk or negedge rst_b) begin // [RQ18]
            if (!rst_b) begin
               main_tmr <= '0;
               aux_tmr  <= '0;
            end else if (clk_en) begin
               if (sn[s].main_ilim && main_on[s] && main_tmr != ($bits(main_tmr))'(FILTER_CYCLES))
                  main_tmr <= main_tmr + 1'b1;
               else if (!sn[s].main_ilim)
                  main_tmr <= '0;
               if (sn[s].aux_ilim && aux_on[s] && aux_tmr != ($bits(aux_tmr))'(FILTER_CYCLES))
                  aux_tmr <= aux_tmr + 1'b1;
               else if (!sn[s].aux_ilim)
                  aux_tmr <= '0;
            end
         end
         // forced-on suppresses all trips; standby undervoltage only blocks the output
         assign main_trip = !forced[s] && main_on[s] && // [RQ13]
                            (main_tmr == ($bits(main_tmr))'(FILTER_CYCLES) ||
                             sn[s].main_uv || sn[s].over_temp);
         assign aux_trip  = !forced[s] && aux_on[s] &&
                            (aux_tmr == ($bits(aux_tmr))'(FILTER_CYCLES) || sn[s].over_temp);
         always_ff @(posedge ref_clk or negedge rst_b) begin // [RQ23]
            if (!rst_b) begin
               main_prev[s] <= 1'b0;
               aux_prev[s]  <= 1'b0;
            end else if (clk_en) begin
               main_prev[s] <= en_main[s];
               aux_prev[s]  <= en_aux[s];
            end
         end
         // fault latches: a new trip wins over a clearing low enable
         always_ff @(posedge ref_clk or negedge rst_b) begin // [RQ23]
            if (!rst_b) begin
               main_flt[s] <= 1'b0;
               aux_flt[s]  <= 1'b0;
            end else if (clk_en) begin
               if (main_trip)
                  main_flt[s] <= 1'b1; // [RQ18]
               else if (!en_main[s])
                  main_flt[s] <= 1'b0; // [RQ3] [RQ9]
               if (aux_trip)
                  aux_flt[s] <= 1'b1;
               else if (!en_aux[s])
                  aux_flt[s] <= 1'b0; // [RQ5] [RQ10]
            end
         end
         // rail commands: pin edge toggles, register write sets; trip drops both main rails
         always_ff @(posedge ref_clk or negedge rst_b) begin // [RQ23]
            if (!rst_b) begin
               main_on[s] <= 1'b0;
               aux_on[s]  <= 1'b0;
            end else if (clk_en) begin
               if (main_trip)
                  main_on[s] <= 1'b0; // [RQ20]
               else if (main_rise && (main_on[s] || por_done))
                  main_on[s] <= !main_on[s]; // [RQ1] [RQ2]
               else if (reg_main_set[s] && (por_done || !wr_data[hps_pkg::CTRL_MAIN_ON]))
                  main_on[s] <= wr_data[hps_pkg::CTRL_MAIN_ON];
               if (aux_trip)
                  aux_on[s] <= 1'b0;
               else if (aux_rise && (aux_on[s] || por_done))
                  aux_on[s] <= !aux_on[s]; // [RQ4] [RQ2]
               else if (reg_aux_set[s] && (por_done || !wr_data[hps_pkg::CTRL_AUX_ON]))
                  aux_on[s] <= wr_data[hps_pkg::CTRL_AUX_ON];
            end
         end
         // rail drive; standby undervoltage lockout holds even when forced
         assign rail[s].main_on = main_on[s] || forced[s]; // [RQ12] [RQ13]
         assign rail[s].aux_on  = (aux_on[s] || forced[s]) && !sn[s].aux_uv; // [RQ14]
         // open-drain pins released while forced
         always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
               power_good_n_oe[s] <= 1'b0;
               fault_n_oe[s]      <= 1'b0;
            end else if (clk_en) begin
               power_good_n_oe[s] <= !forced[s] && main_on[s] && aux_on[s] && // [RQ7] [RQ15]
                                     sn[s].main_good && sn[s].aux_good;
               fault_n_oe[s]      <= !forced[s] && (main_flt[s] || aux_flt[s]); // [RQ8] [RQ11]
            end
         end
         assign reg_main_set[s] = wr_fire && wr_addr[3:0] == (s ? hps_pkg::CTRL_B_OFF :
                                  hps_pkg::CTRL_A_OFF) && !wr_addr[4] && s_axi_wstrb[0];
         assign reg_aux_set[s]  = reg_main_set[s];
      end
   endgenerate
   assign power_good_n_o = 2'b00;
   assign fault_n_o      = 2'b00;

   // =========================================================
   // interrupt, open-drain
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b)
         irq_n_oe <= 1'b0;
      else if (clk_en)
         irq_n_oe <= !interrupt_mask_bit && |{main_flt, aux_flt}; // [RQ21]
   end
   assign irq_n_o = 1'b0;

   // =========================================================
   // axi4-lite write: address and data taken in either order
   logic        aw_held;
   logic        w_held;
   logic        wr_ok;
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign wr_fire = (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid) && !s_axi_bvalid;
   logic [4:0]  aw_q;
   logic [31:0] w_q;
   assign wr_addr = aw_held ? aw_q : s_axi_awaddr;
   assign wr_data = w_held ? w_q : s_axi_wdata;
   assign wr_ok   = wr_addr[1:0] == 2'h0 && (!wr_addr[4] || wr_addr == hps_pkg::COMMON_ADDR);
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_q         <= '0;
         w_q          <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= hps_pkg::AXI_OKAY;
      end else if (clk_en) begin
         if (wr_fire) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? hps_pkg::AXI_OKAY : hps_pkg::AXI_SLVERR;
         end else begin
            if (s_axi_awvalid && s_axi_awready) begin
               aw_held <= 1'b1;
               aw_q    <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
               w_held <= 1'b1;
               w_q    <= s_axi_wdata;
            end
            if (s_axi_bvalid && s_axi_bready)
               s_axi_bvalid <= 1'b0;
         end
      end
   end
   always_ff @(posedge ref_clk or negedge rst_b) begin // [RQ19]
      if (!rst_b) begin
         slot_control_reg   <= {hps_pkg::CTRL_RESET, hps_pkg::CTRL_RESET};
         interrupt_mask_bit <= 1'b0;
      end else if (clk_en && wr_fire && s_axi_wstrb[0]) begin
         if (wr_addr == {1'b0, hps_pkg::CTRL_A_OFF})
            slot_control_reg[0] <= wr_data[7:0];
         if (wr_addr == {1'b0, hps_pkg::CTRL_B_OFF})
            slot_control_reg[1] <= wr_data[7:0];
         if (wr_addr == hps_pkg::COMMON_ADDR)
            interrupt_mask_bit <= wr_data[hps_pkg::COMMON_MASK];
      end
   end

   // =========================================================
   // axi4-lite read: status shows true supply state, not pin overrides
   function automatic logic [7:0] stat_byte(input int k);
      stat_byte = {1'b0, forced[k], sn[k].aux_good, sn[k].main_good,
                   aux_flt[k], main_flt[k], aux_on[k], main_on[k]}; // [RQ16]
   endfunction
   logic [31:0] rd_mux;
   logic        rd_ok;
   always_comb begin
      rd_mux = '0;
      rd_ok  = 1'b1;
      unique case (s_axi_araddr)
         {1'b0, hps_pkg::CTRL_A_OFF}: rd_mux = {24'h0, slot_control_reg[0]};
         {1'b0, hps_pkg::CTRL_B_OFF}: rd_mux = {24'h0, slot_control_reg[1]};
         {1'b0, hps_pkg::STAT_A_OFF}: rd_mux = {24'h0, stat_byte(0)};
         {1'b0, hps_pkg::STAT_B_OFF}: rd_mux = {24'h0, stat_byte(1)};
         hps_pkg::COMMON_ADDR:        rd_mux = {28'h0, interrupt_mask_bit, 1'b0, por_done, sup_ok};
         default:                     rd_ok  = 1'b0;
      endcase
   end
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= hps_pkg::AXI_OKAY;
      end else if (clk_en) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_ok ? rd_mux : 32'h0;
            s_axi_rresp  <= rd_ok ? hps_pkg::AXI_OKAY : hps_pkg::AXI_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

/* File: hps_slot_checker.sv */
// port timing checker for the two-slot hot-plug slot logic
// assumes it is bound to hps_slot_logic and sees only that module's ports
`timescale 1ns/1ps
module hps_slot_checker #(
   parameter int POR_CYCLES    = 20,
   parameter int FILTER_CYCLES = 5
) (
   // clock and reset
   input wire logic                         ref_clk,
   input wire logic                         rst_b,
   input wire logic                         clk_en,
   // pins
   input wire logic [1:0]                   force_on_n,
   input wire hps_pkg::hps_sense_type [1:0] sense,
   input wire hps_pkg::hps_rail_type [1:0]  rail,
   input wire logic [1:0]                   power_good_n_oe,
   input wire logic [1:0]                   fault_n_oe,
   // bus
   input wire logic                         s_axi_awvalid,
   input wire logic                         s_axi_awready,
   input wire logic                         s_axi_wvalid,
   input wire logic                         s_axi_wready,
   input wire logic                         s_axi_bvalid,
   input wire logic                         s_axi_bready,
   input wire logic [1:0]                   s_axi_bresp,
   input wire logic                         s_axi_arvalid,
   input wire logic                         s_axi_arready,
   input wire logic                         s_axi_rvalid,
   input wire logic                         s_axi_rready,
   input wire logic [31:0]                  s_axi_rdata
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // ==========================================================
   // steps
   // eight cycles covers sync, force release and the filter count
   sequence s_limit;
      (sense[0].main_ilim && force_on_n[0] && clk_en)[*8];
   endsequence
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // ==========================================================
   // rules
   a_por_quiet: assert property ($rose(rst_b) |->
      (rail == 4'h0 && fault_n_oe == 2'h0)[*8])
      else $error("rail or fault active right after reset");
   a_trip_main: assert property (s_limit |-> ##[0:6] !rail[0].main_on)
      else $error("main rail kept on through long current limit");
   a_pg_rails: assert property (power_good_n_oe[0] |-> $past(rail[0] == 2'h3, 3))
      else $error("power good without both rails on");
   a_fault_rail: assert property ($rose(fault_n_oe[0]) |-> rail[0] != 2'h3)
      else $error("fault raised with both rails still on");
   a_wr_answer: assert property (s_wr_taken |=> s_axi_bvalid)
      else $error("no write response after address and data");
   a_wr_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("no read data after address");
   a_rd_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
endmodule

bind hps_slot_logic hps_slot_checker #(.POR_CYCLES(POR_CYCLES), .FILTER_CYCLES(FILTER_CYCLES))
   chk_u (
   .ref_clk, .rst_b, .clk_en, .force_on_n, .sense, .rail, .power_good_n_oe, .fault_n_oe,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

/* File: hps_slot_model.sv */
// slot switch model: each rail reports good some cycles after it is switched on
// assumes fault levels are injected by the bench
`timescale 1ns/1ps
module hps_slot_model #(
   parameter int DLY = 2
) (
   // clock
   input wire logic                         ref_clk,
   // switch drive and injected faults
   input wire hps_pkg::hps_rail_type [1:0]  rail,
   input wire hps_pkg::hps_sense_type [1:0] inj,
   // sense back to the controller
   output hps_pkg::hps_sense_type [1:0]     sense
);
   int m_cnt [2];
   int a_cnt [2];
   // ==========================================================
   // ramp timers, slot b slower so both prompt and slow rails are seen
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < 2; i++) begin
         m_cnt[i] <= rail[i].main_on ? m_cnt[i] + 1 : 0;
         a_cnt[i] <= rail[i].aux_on ? a_cnt[i] + 1 : 0;
      end
   end
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         sense[i] = inj[i];
         sense[i].main_good = m_cnt[i] > DLY + 4 * i;
         sense[i].aux_good = a_cnt[i] > DLY + 4 * i;
      end
   end
endmodule

/* File: hps_slot_logic_tb.sv */
// self-checking bench for the two-slot hot-plug slot logic
// assumes the design, its checker and the slot switch model are compiled first
`timescale 1ns/1ps
module hps_slot_logic_tb;
   localparam logic [4:0] C_A = 5'h00;
   localparam logic [4:0] C_B = 5'h04;
   localparam logic [4:0] S_A = 5'h08;
   localparam logic [4:0] S_B = 5'h0c;
   logic                         ref_clk, rst_b, clk_en, standby_supply_ok, irq_n_o, irq_n_oe;
   logic [1:0]                   main_enable_in, standby_rail_enable_in, force_on_n;
   logic [1:0]                   power_good_n_o, power_good_n_oe, fault_n_o, fault_n_oe;
   hps_pkg::hps_sense_type [1:0] sense, inj;
   hps_pkg::hps_rail_type [1:0]  rail;
   logic [4:0]                   awaddr, araddr;
   logic [31:0]                  wdata, rdata, seed;
   logic [1:0]                   bresp, rresp;
   logic                         awvalid, awready, wvalid, wready, bvalid, bready;
   logic                         arvalid, arready, rvalid, rready;
   logic [33:0]                  exp_q[$], msk_q[$];
   int                           n_mismatch, n_tests, cyc_n;
   // ==========================================================
   // design and partner
   hps_slot_logic #(.POR_CYCLES(20), .FILTER_CYCLES(5)) dut_u (
      .ref_clk, .rst_b, .clk_en, .standby_supply_ok, .main_enable_in, .standby_rail_enable_in,
      .force_on_n, .sense, .rail, .power_good_n_o, .power_good_n_oe, .fault_n_o, .fault_n_oe,
      .irq_n_o, .irq_n_oe, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   hps_slot_model #(.DLY(2)) model_u (.ref_clk, .rail, .inj, .sense);
   // ==========================================================
   // clock, timeout, read monitor
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc_n++;
      if (cyc_n == 20000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   // rvalid is registered, so the negedge sees it one time per read
   always @(negedge ref_clk) begin
      if (rvalid && rready) begin
         cmp_rd({rresp, rdata}, exp_q.pop_front(), msk_q.pop_front());
      end
   end
   // ==========================================================
   // tasks
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic gap();
      seed = xs(seed);
      cyc(1 + int'(seed[1:0]));
   endtask
   task automatic cmp_rd(input logic [33:0] g, e, m);
      n_tests++;
      if (((g ^ e) & m) !== 34'h0) begin
         n_mismatch++;
         $display("[FAIL] t=%0t read got %h exp %h", $time, g, e);
      end
   endtask
   // pin values are taken as they stood just before the calling edge
   task automatic cp(input logic [7:0] g, e);
      @(negedge ref_clk);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] t=%0t pin got %h exp %h", $time, g, e);
      end
      @(posedge ref_clk);
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic ta = 1'b0;
      logic tw = 1'b0;
      gap();
      awaddr <= a;
      wdata <= {seed[31:8], d};
      {awvalid, wvalid, bready} <= 3'h7;
      do begin
         @(negedge ref_clk);
         ta = ta || (awvalid && awready);
         tw = tw || (wvalid && wready);
         @(posedge ref_clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end while (!(ta && tw));
      do @(negedge ref_clk); while (!bvalid);
      @(posedge ref_clk);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [33:0] e, m);
      gap();
      exp_q.push_back(e);
      msk_q.push_back(m);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      do @(negedge ref_clk); while (!arready);
      @(posedge ref_clk);
      arvalid <= 1'b0;
      do @(negedge ref_clk); while (!rvalid);
      @(posedge ref_clk);
      rready <= 1'b0;
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ==========================================================
   // scenarios
   initial begin
      seed = 32'h2d30;
      {rst_b, main_enable_in, standby_rail_enable_in, inj} = '0;
      {clk_en, standby_supply_ok, force_on_n} = 4'hf;
      {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
      repeat (6) @(posedge ref_clk);
      rst_b <= 1'b1;
      main_enable_in[0] <= 1'b1;
      cyc(8);
      cp(rail[0], 8'h0);
      rd(hps_pkg::COMMON_ADDR, 34'h1, 34'h3_0000_0003);
      rd(C_A, 34'h0, 34'h3_0000_00ff);
      rd(5'h14, {hps_pkg::AXI_SLVERR, 32'h0}, 34'h3_ffff_ffff);
      main_enable_in[0] <= 1'b0;
      cyc(30);
      main_enable_in[0] <= 1'b1;
      cyc(5);
      cp(rail[0], 8'h2);
      cp(power_good_n_oe[0], 8'h0);
      standby_rail_enable_in[0] <= 1'b1;
      cyc(12);
      cp(rail[0], 8'h3);
      cp(power_good_n_oe[0], 8'h1);
      inj[0].main_ilim <= 1'b1;
      cyc(14);
      cp(rail[0], 8'h1);
      cp(fault_n_oe[0], 8'h1);
      cp(irq_n_oe, 8'h1);
      inj[0].main_ilim <= 1'b0;
      cyc(4);
      cp(fault_n_oe[0], 8'h1);
      wr(hps_pkg::COMMON_ADDR, 8'h08);
      cyc(3);
      cp(irq_n_oe, 8'h0);
      wr(hps_pkg::COMMON_ADDR, 8'h00);
      cyc(1);
      cp(irq_n_oe, 8'h1);
      cp({power_good_n_o, fault_n_o, irq_n_o}, 8'h0);
      rd(S_A, 34'h4, 34'h3_0000_0004);
      {main_enable_in[0], standby_rail_enable_in[0]} <= 2'h0;
      cyc(6);
      cp(fault_n_oe[0], 8'h0);
      wr(C_A, 8'h03);
      cyc(3);
      cp(rail[0], 8'h3);
      rd(C_A, 34'h3, 34'h3_0000_00ff);
      {force_on_n[0], inj[0].over_temp} <= 2'h1;
      cyc(4);
      rd(S_A, 34'h3, 34'h3_0000_000f);
      {force_on_n[0], inj[0].over_temp} <= 2'h2;
      {main_enable_in[1], standby_rail_enable_in[1]} <= 2'h3;
      cyc(20);
      cp(rail[1], 8'h3);
      {inj[1].main_ilim, inj[1].aux_ilim} <= 2'h3;
      cyc(14);
      inj[1] <= '0;
      cyc(4);
      cp(fault_n_oe[1], 8'h1);
      rd(S_B, 34'hc, 34'h3_0000_000c);
      main_enable_in[1] <= 1'b0;
      cyc(6);
      cp(fault_n_oe[1], 8'h1);
      standby_rail_enable_in[1] <= 1'b0;
      cyc(6);
      cp(fault_n_oe[1], 8'h0);
      force_on_n[1] <= 1'b0;
      inj[1].main_ilim <= 1'b1;
      cyc(14);
      cp(rail[1], 8'h3);
      cp({power_good_n_oe[1], fault_n_oe[1]}, 8'h0);
      rd(S_B, 34'h40, 34'h3_0000_004c);
      inj[1].aux_uv <= 1'b1;
      cyc(5);
      cp(rail[1], 8'h2);
      inj[1] <= '0;
      wr(C_B, 8'h04);
      cyc(5);
      cp(rail[1], 8'h0);
      rd(S_B, 34'h0, 34'h3_0000_0040);
      force_on_n[1] <= 1'b1;
      cyc(4);
      tally_and_finish();
   end
endmodule
